// ==== common/usfc_regs.svh ====
`ifndef USFC_REGS_SVH
`define USFC_REGS_SVH
// Word offsets (byte address = 4 * index)
`define USFC_IDX_EFR      4'h0
`define USFC_IDX_IER      4'h1
`define USFC_IDX_ISR      4'h2
`define USFC_IDX_FCR      4'h3
`define USFC_IDX_MCR      4'h4
`define USFC_IDX_MSR      4'h5
`define USFC_IDX_TX_FIFO_LEVEL_COUNT    4'h6
`define USFC_IDX_TX_FIFO_TRIGGER_LEVEL    4'h7
`define USFC_IDX_RX_FIFO_LEVEL_COUNT    4'h8
`define USFC_IDX_RX_FIFO_TRIGGER_LEVEL    4'h9
`define USFC_IDX_STOP1    4'ha
`define USFC_IDX_STOP2    4'hb
`define USFC_IDX_RES1     4'hc
`define USFC_IDX_RES2     4'hd
`define USFC_IDX_XSTAT    4'he
`define USFC_EFR_SCD      5
`define USFC_EFR_ENH      4
`define USFC_EFR_TX       3:2
`define USFC_EFR_RX       1:0
`define USFC_EFR_FLOW     3:0
`define USFC_XS_RSVD      7:4
`define USFC_ZERO4        4'h0
`define USFC_IER_MASK     8'he0
`define USFC_ISR_MASK     8'h30
`define USFC_FCR_MASK     8'h30
`define USFC_MCR_MASK     8'hec
`define USFC_MSR_MASK     8'hfc
`define USFC_ISR_SPECIAL  4
`define USFC_ISR_STOP     5
`define USFC_XS_TX_RES    3
`define USFC_XS_TX_STOP   2
`define USFC_XS_RX_RES    1
`define USFC_XS_RX_STOP   0
`define USFC_SEL_NONE     2'h0
`define USFC_SEL_FIRST    2'h2
`define USFC_SEL_SECOND   2'h1
`define USFC_SEL_BOTH     2'h3
`define USFC_FIFO_MAX     8'h40
`define USFC_ZERO8        8'h00
`endif

// ==== common/usfc_pkg.sv ====
package usfc_pkg;
  typedef enum logic [1:0] {USFC_IDLE, USFC_GOT_FIRST} usfc_seq_t;
  typedef enum logic [1:0] {USFC_TX_IDLE, USFC_TX_SECOND} usfc_tx_t;
endpackage

// ==== core/usfc_char_match.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "usfc_regs.svh"
// Receive-side control character classifier
module usfc_char_match (
  input  wire logic [7:0] char_in,
  input  wire logic [1:0] rx_sel_in,
  input  wire logic [7:0] stop1_in,
  input  wire logic [7:0] stop2_in,
  input  wire logic [7:0] res1_in,
  input  wire logic [7:0] res2_in,
  output logic            is_stop1_out,
  output logic            is_stop2_out,
  output logic            is_res1_out,
  output logic            is_res2_out,
  output logic            special_out
);
  // Bit 0 of each character register lines up with the received LSB
  always_comb begin
    is_stop1_out = (char_in == stop1_in);
    is_stop2_out = (char_in == stop2_in);
    is_res1_out  = (char_in == res1_in);
    is_res2_out  = (char_in == res2_in);
    special_out  = is_stop2_out;
  end
  logic unused_sel;
  assign unused_sel = ^rx_sel_in;
endmodule
`default_nettype wire

// ==== core/usfc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "usfc_regs.svh"
// How it works
// - Special detect: match second stop, store, flag
// - Detect plus first-pair receive both work independently
// - Detect plus second pair: drop char, two interrupts
// - Enhanced bits writable only while enable set
// - Reset clears enhanced bits and enable
// - Transmit flow selected by bits three two
// - Receive flow selected by bits one zero
// - Mixed select: either character of pair counts
// - Both selects: pair must arrive in sequence
// - Transmit level counter reads FIFO occupancy
// - Transmit interrupt while level below trigger
// - Receive level counter reads FIFO occupancy
// - Receive interrupt when level reaches trigger
// - Four character registers hold stop/resume
// - Status reads zero while flow disabled
// - Transmit resume/stop bits, cleared by read
// - Receive resume/stop bits, cleared by read
// - Modem status reset: low zero, high inputs
// - Reset pin levels: serial/modem high, others low
// - Dual characters sent or matched consecutively
module usfc_top #(
  parameter int FIFO_DEPTH = 64
) (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        rx_valid_in,
  input  wire logic [7:0]  rx_char_in,
  output logic             rx_store_out,
  input  wire logic        rx_fifo_pop_in,
  input  wire logic        tx_fifo_push_in,
  input  wire logic        tx_fifo_pop_in,
  input  wire logic        tx_send_resume_in,
  input  wire logic        tx_send_stop_in,
  input  wire logic        tx_char_ready_in,
  output logic             tx_char_valid_out,
  output logic [7:0]       tx_char_out,
  input  wire logic [3:0]  modem_in,
  output logic             rx_resume_out,
  output logic             rx_stop_out,
  output logic             special_irq_out,
  output logic             stop_irq_out,
  output logic             tx_trig_irq_out,
  output logic             rx_trig_irq_out,
  output logic             serial_tx_out,
  output logic             rts_n_out,
  output logic             dtr_n_out,
  output logic             infrared_serial_out,
  output logic             eeprom_serial_clock_out,
  output logic             eeprom_chip_select_out,
  output logic             eeprom_serial_din_out
);
  import usfc_pkg::*;
  if (FIFO_DEPTH < 1 || FIFO_DEPTH > `USFC_FIFO_MAX) begin : g_depth_check
    $error("FIFO_DEPTH must be 1..64");
  end
  typedef struct packed {
    logic [7:0] enhanced_feature_ctrl, interrupt_enable_reg, interrupt_status, fifo_control_reg, modem_control_reg, modem_status_reg;
    logic [7:0] tx_fifo_level_count, tx_fifo_trigger_level, rx_fifo_level_count, rx_fifo_trigger_level;
    logic [7:0] stop1, stop2, res1, res2, xstat;
    usfc_seq_t  rx_seq_res, rx_seq_stop;
    usfc_tx_t   tx_st;
    logic       tx_is_res;
    logic       ack, rx_store, rx_res, rx_stop, msr_init;
    logic       tx_valid;
    logic [7:0] tx_char;
    logic [31:0] rdat;
  } usfc_state_t;
  usfc_state_t st_r, st_nxt;

  function automatic logic [7:0] gated(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask, input logic en);
    gated = en ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  logic m_stop1, m_stop2, m_res1, m_res2, m_special;
  usfc_char_match usfc_char_match_inst (
    .char_in      (rx_char_in),
    .rx_sel_in    (st_r.enhanced_feature_ctrl[`USFC_EFR_RX]),
    .stop1_in     (st_r.stop1),
    .stop2_in     (st_r.stop2),
    .res1_in      (st_r.res1),
    .res2_in      (st_r.res2),
    .is_stop1_out (m_stop1),
    .is_stop2_out (m_stop2),
    .is_res1_out  (m_res1),
    .is_res2_out  (m_res2),
    .special_out  (m_special)
  );

  logic [1:0] rx_sel, tx_sel;
  logic       bus_req, wr, rd, enh, flow_off, scd;
  logic [3:0] idx;
  logic       rx_res_ev, rx_stop_ev, drop_char, tx_start, tx_done;
  assign rx_sel   = st_r.enhanced_feature_ctrl[`USFC_EFR_RX];
  assign tx_sel   = st_r.enhanced_feature_ctrl[`USFC_EFR_TX];
  assign enh      = st_r.enhanced_feature_ctrl[`USFC_EFR_ENH];
  assign scd      = st_r.enhanced_feature_ctrl[`USFC_EFR_SCD];
  assign flow_off = (st_r.enhanced_feature_ctrl[`USFC_EFR_FLOW] == `USFC_ZERO4);
  assign bus_req  = wb_cyc_in && wb_stb_in && !st_r.ack;
  assign wr       = bus_req && wb_we_in && wb_sel_in[0];
  assign rd       = bus_req && !wb_we_in;
  assign idx      = wb_adr_in[5:2];
  assign tx_start = (st_r.tx_st == USFC_TX_IDLE) && !st_r.tx_valid && (tx_sel != `USFC_SEL_NONE)
                    && (tx_send_resume_in || tx_send_stop_in);
  assign tx_done  = st_r.tx_valid && tx_char_ready_in;

  always_comb begin
    logic pair_mode;
    logic [7:0] cnt;
    pair_mode  = 1'b0;
    cnt        = 8'h00;
    st_nxt = st_r;
    rx_res_ev  = 1'b0;
    rx_stop_ev = 1'b0;
    drop_char  = 1'b0;
    st_nxt.ack      = bus_req;
    st_nxt.rx_store = 1'b0;
    st_nxt.rx_res   = 1'b0;
    st_nxt.rx_stop  = 1'b0;
    st_nxt.msr_init = 1'b0;
    // Capture modem inputs on the first clock after release
    if (st_r.msr_init) begin
      st_nxt.modem_status_reg = {modem_in, `USFC_ZERO4};
    end
    // Receive classification
    if (rx_valid_in) begin
      pair_mode = (rx_sel == `USFC_SEL_BOTH) &&
                  (tx_sel == `USFC_SEL_BOTH || tx_sel == `USFC_SEL_NONE);
      case (rx_sel)
        `USFC_SEL_FIRST: begin
          rx_res_ev  = m_res1;
          rx_stop_ev = m_stop1;
        end
        `USFC_SEL_SECOND: begin
          rx_res_ev  = m_res2;
          rx_stop_ev = m_stop2;
        end
        `USFC_SEL_BOTH: begin
          if (pair_mode) begin
            rx_res_ev  = (st_r.rx_seq_res == USFC_GOT_FIRST) && m_res2;
            rx_stop_ev = (st_r.rx_seq_stop == USFC_GOT_FIRST) && m_stop2;
            st_nxt.rx_seq_res  = m_res1 ? USFC_GOT_FIRST : USFC_IDLE;
            st_nxt.rx_seq_stop = m_stop1 ? USFC_GOT_FIRST : USFC_IDLE;
          end else begin
            rx_res_ev  = m_res1 || m_res2;
            rx_stop_ev = m_stop1 || m_stop2;
          end
        end
        default: begin
          rx_res_ev  = 1'b0;
          rx_stop_ev = 1'b0;
        end
      endcase
      // Second stop is swallowed only when it is also a flow-control stop
      drop_char = scd && m_special && (rx_sel == `USFC_SEL_SECOND);
      st_nxt.rx_store = !drop_char;
      st_nxt.rx_res  = rx_res_ev;
      st_nxt.rx_stop = rx_stop_ev;
    end
    // Transmit sequencer
    if (tx_done) begin
      st_nxt.tx_valid = 1'b0;
    end
    case (st_r.tx_st)
      USFC_TX_IDLE: begin
        if (tx_start) begin
          st_nxt.tx_is_res = tx_send_resume_in;
          st_nxt.tx_valid  = 1'b1;
          case (tx_sel)
            `USFC_SEL_SECOND: st_nxt.tx_char = tx_send_resume_in ? st_r.res2 : st_r.stop2;
            default:          st_nxt.tx_char = tx_send_resume_in ? st_r.res1 : st_r.stop1;
          endcase
          if (tx_sel == `USFC_SEL_BOTH) begin
            st_nxt.tx_st = USFC_TX_SECOND;
          end
        end
      end
      USFC_TX_SECOND: begin
        if (tx_done) begin
          st_nxt.tx_valid = 1'b1;
          st_nxt.tx_char  = st_r.tx_is_res ? st_r.res2 : st_r.stop2;
          st_nxt.tx_st    = USFC_TX_IDLE;
        end
      end
      default: st_nxt.tx_st = USFC_TX_IDLE;
    endcase
    // Level counters
    cnt = st_r.tx_fifo_level_count;
    if (tx_fifo_push_in && !tx_fifo_pop_in && cnt < 8'(FIFO_DEPTH)) cnt = cnt + 8'h01;
    else if (tx_fifo_pop_in && !tx_fifo_push_in && cnt != `USFC_ZERO8) cnt = cnt - 8'h01;
    st_nxt.tx_fifo_level_count = cnt;
    cnt = st_r.rx_fifo_level_count;
    if (st_r.rx_store && !rx_fifo_pop_in && cnt < 8'(FIFO_DEPTH)) cnt = cnt + 8'h01;
    else if (rx_fifo_pop_in && !st_r.rx_store && cnt != `USFC_ZERO8) cnt = cnt - 8'h01;
    st_nxt.rx_fifo_level_count = cnt;
    // Register writes
    if (wr) begin
      case (idx)
        `USFC_IDX_EFR:   st_nxt.enhanced_feature_ctrl = wb_dat_in[7:0];
        `USFC_IDX_IER:   st_nxt.interrupt_enable_reg = gated(st_r.interrupt_enable_reg, wb_dat_in[7:0], `USFC_IER_MASK, enh);
        `USFC_IDX_ISR:   st_nxt.interrupt_status = gated(st_r.interrupt_status, wb_dat_in[7:0], `USFC_ISR_MASK, enh);
        `USFC_IDX_FCR:   st_nxt.fifo_control_reg = gated(st_r.fifo_control_reg, wb_dat_in[7:0], `USFC_FCR_MASK, enh);
        `USFC_IDX_MCR:   st_nxt.modem_control_reg = gated(st_r.modem_control_reg, wb_dat_in[7:0], `USFC_MCR_MASK, enh);
        `USFC_IDX_MSR:   st_nxt.modem_status_reg = gated(st_r.modem_status_reg, wb_dat_in[7:0], `USFC_MSR_MASK, enh);
        `USFC_IDX_TX_FIFO_TRIGGER_LEVEL: st_nxt.tx_fifo_trigger_level = (wb_dat_in[7:0] > `USFC_FIFO_MAX) ? `USFC_FIFO_MAX
                                        : wb_dat_in[7:0];
        `USFC_IDX_RX_FIFO_TRIGGER_LEVEL: st_nxt.rx_fifo_trigger_level = (wb_dat_in[7:0] > `USFC_FIFO_MAX) ? `USFC_FIFO_MAX
                                        : wb_dat_in[7:0];
        `USFC_IDX_STOP1: st_nxt.stop1 = wb_dat_in[7:0];
        `USFC_IDX_STOP2: st_nxt.stop2 = wb_dat_in[7:0];
        `USFC_IDX_RES1:  st_nxt.res1  = wb_dat_in[7:0];
        `USFC_IDX_RES2:  st_nxt.res2  = wb_dat_in[7:0];
        default: ;
      endcase
    end
    // Flags are set after the write so that a same-cycle clear cannot lose an event
    if (rx_valid_in && scd && m_special) begin
      st_nxt.interrupt_status[`USFC_ISR_SPECIAL] = 1'b1;
    end
    if (drop_char) begin
      st_nxt.interrupt_status[`USFC_ISR_STOP] = 1'b1;
    end
    // Reads; write-only registers read as zero
    st_nxt.rdat = 32'h0;
    if (rd) begin
      case (idx)
        `USFC_IDX_EFR:   st_nxt.rdat[7:0] = st_r.enhanced_feature_ctrl;
        `USFC_IDX_IER:   st_nxt.rdat[7:0] = st_r.interrupt_enable_reg;
        `USFC_IDX_ISR:   st_nxt.rdat[7:0] = st_r.interrupt_status;
        `USFC_IDX_FCR:   st_nxt.rdat[7:0] = st_r.fifo_control_reg;
        `USFC_IDX_MCR:   st_nxt.rdat[7:0] = st_r.modem_control_reg;
        `USFC_IDX_MSR:   st_nxt.rdat[7:0] = st_r.modem_status_reg;
        `USFC_IDX_TX_FIFO_LEVEL_COUNT: st_nxt.rdat[7:0] = st_r.tx_fifo_level_count;
        `USFC_IDX_RX_FIFO_LEVEL_COUNT: st_nxt.rdat[7:0] = st_r.rx_fifo_level_count;
        `USFC_IDX_XSTAT: st_nxt.rdat[7:0] = st_r.xstat;
        default:         st_nxt.rdat = 32'h0;
      endcase
    end
    // Control character status: clear on read, set wins
    if (rd && idx == `USFC_IDX_XSTAT) begin
      st_nxt.xstat = 8'h00;
    end
    if (tx_done) begin
      st_nxt.xstat[`USFC_XS_TX_RES]  = st_r.tx_is_res;
      st_nxt.xstat[`USFC_XS_TX_STOP] = !st_r.tx_is_res;
    end
    if (rx_res_ev || rx_stop_ev) begin
      st_nxt.xstat[`USFC_XS_RX_RES]  = rx_res_ev;
      st_nxt.xstat[`USFC_XS_RX_STOP] = rx_stop_ev;
    end
    st_nxt.xstat[`USFC_XS_RSVD] = `USFC_ZERO4;
    if (st_nxt.enhanced_feature_ctrl[`USFC_EFR_FLOW] == `USFC_ZERO4) begin
      st_nxt.xstat = `USFC_ZERO8;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r          <= '0;
      st_r.msr_init <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_out          = st_r.ack;
  assign wb_dat_out          = st_r.rdat;
  assign rx_store_out        = st_r.rx_store;
  assign rx_resume_out       = st_r.rx_res;
  assign rx_stop_out         = st_r.rx_stop;
  assign special_irq_out     = st_r.interrupt_status[`USFC_ISR_SPECIAL];
  assign stop_irq_out        = st_r.interrupt_status[`USFC_ISR_STOP];
  assign tx_trig_irq_out     = st_r.tx_fifo_level_count < st_r.tx_fifo_trigger_level;
  assign rx_trig_irq_out     = (st_r.rx_fifo_trigger_level != `USFC_ZERO8) && (st_r.rx_fifo_level_count >= st_r.rx_fifo_trigger_level);
  assign tx_char_valid_out   = st_r.tx_valid;
  assign tx_char_out         = st_r.tx_char;
  assign serial_tx_out       = 1'b1;
  assign rts_n_out           = 1'b1;
  assign dtr_n_out           = 1'b1;
  assign infrared_serial_out = 1'b0;
  assign eeprom_serial_clock_out = 1'b0;
  assign eeprom_chip_select_out  = 1'b0;
  assign eeprom_serial_din_out   = 1'b0;

  property p_ack_one;
    @(posedge clk_in) disable iff (reset_in) wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
  property p_xstat_off;
    @(posedge clk_in) disable iff (reset_in) flow_off |-> st_r.xstat == 8'h00;
  endproperty
  a_xstat_off: assert property (p_xstat_off) else $error("status not zero");
  property p_drop;
    @(posedge clk_in) disable iff (reset_in)
      (rx_valid_in && scd && m_special && rx_sel == 2'h1) |=> !rx_store_out && stop_irq_out;
  endproperty
  a_drop: assert property (p_drop) else $error("second stop stored");
  property p_special;
    @(posedge clk_in) disable iff (reset_in)
      (rx_valid_in && scd && m_special && rx_sel != 2'h1) |=> rx_store_out && special_irq_out;
  endproperty
  a_special: assert property (p_special) else $error("special not flagged");
  property p_tx_trig;
    @(posedge clk_in) disable iff (reset_in)
      (tx_fifo_pop_in && !tx_fifo_push_in && !wr && st_r.tx_fifo_trigger_level != 8'h00 &&
       st_r.tx_fifo_level_count == st_r.tx_fifo_trigger_level) |=> tx_trig_irq_out;
  endproperty
  a_tx_trig: assert property (p_tx_trig) else $error("tx trigger wrong");
  property p_cnt_max;
    @(posedge clk_in) disable iff (reset_in) st_r.tx_fifo_level_count <= 8'h40 && st_r.rx_fifo_level_count <= 8'h40;
  endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("level over max");
  property p_lock;
    @(posedge clk_in) disable iff (reset_in)
      (wr && idx == 4'h1 && !enh) |=> st_r.interrupt_enable_reg[7:5] == $past(st_r.interrupt_enable_reg[7:5]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked bits changed");
  // Checker memory: was the last pair-mode character the first resume
  logic pair_res1_r;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pair_res1_r <= 1'b0;
    end else if (rx_valid_in && rx_sel == 2'h3 && (tx_sel == 2'h3 || tx_sel == 2'h0)) begin
      pair_res1_r <= m_res1;
    end
  end
  sequence s_pair_tail;
    rx_valid_in && m_res2 && pair_res1_r && rx_sel == 2'h3 && tx_sel == 2'h3;
  endsequence
  property p_pair;
    @(posedge clk_in) disable iff (reset_in)
      (rx_valid_in && rx_sel == 2'h3 && tx_sel == 2'h3 && !pair_res1_r) |=> !rx_resume_out;
  endproperty
  a_pair: assert property (p_pair) else $error("lone resume accepted");
  property p_pair_done;
    @(posedge clk_in) disable iff (reset_in) s_pair_tail |=> rx_resume_out;
  endproperty
  a_pair_done: assert property (p_pair_done) else $error("resume pair missed");
  property p_pins;
    @(posedge clk_in) serial_tx_out && rts_n_out && !eeprom_chip_select_out;
  endproperty
  a_pins: assert property (p_pins) else $error("pin level wrong");
endmodule
`default_nettype wire

// ==== testbench/usfc_remote.sv ====
`timescale 1ns/1ps
`default_nettype none
// Far-end serial device: feeds received characters, drains sent ones
module usfc_remote (
  input  wire logic       clk_in,
  input  wire logic       slow_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_char_in,
  output logic            tx_ready_out,
  output logic            rx_valid_out,
  output logic [7:0]      rx_char_out
);
  logic [7:0] got[$];
  logic       tog = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_char_out  = 8'h00;
  end
  // A slow line accepts only every other cycle
  assign tx_ready_out = slow_in ? tog : 1'b1;
  always @(posedge clk_in) begin
    tog <= ~tog;
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
      got.push_back(tx_char_in);
    end
  end
  task automatic send(input logic [7:0] c);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_char_out  <= c;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    // Data is meaningless between characters, so show another byte
    rx_char_out  <= ~c;
  endtask
endmodule
`default_nettype wire

// ==== testbench/uart_soft_flow_control_fifo_levels_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module uart_soft_flow_control_fifo_levels_tb;
  logic        clk_in = 1'b0, reset_in = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, slow = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        store, res, stp, spec, stpi, txi, rxi, txv, txrdy, rxv;
  logic        stx, rts_n, dtr_n, irx, eck, ecs, edi;
  logic        rpop = 1'b0, tpush = 1'b0, tpop = 1'b0, sres = 1'b0, sstp = 1'b0;
  logic [7:0]  rxc, txc, plain, ch[4];
  logic [3:0]  modem;
  logic [7:0]  expq[$];
  int          bad_count = 0, n_checks = 0;

  usfc_top #(.FIFO_DEPTH(64)) usfc_top_inst (.clk_in(clk_in), .reset_in(reset_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
    .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .rx_valid_in(rxv),
    .rx_char_in(rxc), .rx_store_out(store), .rx_fifo_pop_in(rpop), .tx_fifo_push_in(tpush),
    .tx_fifo_pop_in(tpop), .tx_send_resume_in(sres), .tx_send_stop_in(sstp),
    .tx_char_ready_in(txrdy), .tx_char_valid_out(txv), .tx_char_out(txc), .modem_in(modem),
    .rx_resume_out(res), .rx_stop_out(stp), .special_irq_out(spec), .stop_irq_out(stpi),
    .tx_trig_irq_out(txi), .rx_trig_irq_out(rxi), .serial_tx_out(stx), .rts_n_out(rts_n),
    .dtr_n_out(dtr_n), .infrared_serial_out(irx), .eeprom_serial_clock_out(eck),
    .eeprom_chip_select_out(ecs), .eeprom_serial_din_out(edi));
  usfc_remote usfc_remote_inst (.clk_in(clk_in), .slow_in(slow), .tx_valid_in(txv),
    .tx_char_in(txc), .tx_ready_out(txrdy), .rx_valid_out(rxv), .rx_char_out(rxc));

  always #10 clk_in = ~clk_in;

  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_in);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {i, 2'b00};
    wdat <= {24'h0, d};
    sel  <= 4'h1;
    do @(posedge clk_in); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, i, 8'h00);
  endtask
  task automatic setf(input logic [7:0] v);
    wr(4'h0, 8'h00);
    wr(4'h0, v);
  endtask
  // Received char; mask and expected cover {store, resume, stop}
  task automatic rxg(input logic [7:0] c, input logic [7:0] m, input logic [7:0] e);
    usfc_remote_inst.send(c);
    #1;
    chk({5'h0, store, res, stp} & m, e);
  endtask
  task automatic pulse_cnt;
    @(posedge clk_in);
    #1;
  endtask

  // Read data is judged where the answer appears, against the oldest note
  always @(posedge clk_in) begin
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
      chk(rdat[7:0], expq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h5e30ea5f));
    modem = 4'($urandom);
    ch[0] = 8'($urandom);
    for (int i = 1; i < 4; i++) ch[i] = ch[i-1] + 8'h11;
    plain = ch[0] + 8'h88;
    repeat (16) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk({1'b0, stx, rts_n, dtr_n, irx, eck, ecs, edi}, 8'h70);
    rd(4'h5, {modem, 4'h0});
    rd(4'h0, 8'h00);
    rd(4'h6, 8'h00);
    rd(4'h8, 8'h00);
    rd(4'he, 8'h00);
    rd(4'h7, 8'h00);
    rd(4'hf, 8'h00);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h1f);
    setf(8'h10);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'hff);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'he0);
    for (int i = 0; i < 4; i++) wr(4'(10 + i), ch[i]);
    for (int k = 0; k < 2; k++) begin
      setf(k == 1 ? 8'h01 : 8'h02);
      rxg(ch[2+k], 8'h06, 8'h06);
      rd(4'he, 8'h02);
      rd(4'he, 8'h00);
      rxg(ch[k], 8'h03, 8'h01);
      rd(4'he, 8'h01);
      rxg(ch[3-k], 8'h07, 8'h04);
    end
    setf(8'h0b);
    for (int i = 3; i >= 0; i--) rxg(ch[i], 8'h03, i > 1 ? 8'h02 : 8'h01);
    for (int v = 0; v < 2; v++) begin
      setf(v == 0 ? 8'h0f : 8'h03);
      rxg(ch[2], 8'h03, 8'h00);
      rxg(ch[3], 8'h03, 8'h02);
      rxg(ch[0], 8'h03, 8'h00);
      rxg(ch[1], 8'h03, 8'h01);
    end
    setf(8'h00);
    rd(4'he, 8'h00);
    setf(8'h30);
    rxg(ch[1], 8'h04, 8'h04);
    chk({7'h0, spec}, 8'h01);
    wr(4'h2, 8'h00);
    #1;
    chk({6'h0, spec, stpi}, 8'h00);
    setf(8'h31);
    rxg(ch[1], 8'h07, 8'h01);
    chk({6'h0, spec, stpi}, 8'h03);
    wr(4'h2, 8'h00);
    setf(8'h32);
    rxg(ch[1], 8'h04, 8'h04);
    rxg(ch[2], 8'h02, 8'h02);
    for (int t = 0; t < 3; t++) begin
      setf(t == 0 ? 8'h18 : t == 1 ? 8'h14 : 8'h1c);
      slow <= (t == 2);
      usfc_remote_inst.got.delete();
      @(posedge clk_in);
      sres <= (t != 1);
      sstp <= (t == 1);
      @(posedge clk_in);
      sres <= 1'b0;
      sstp <= 1'b0;
      for (int w = 0; w < 60 && usfc_remote_inst.got.size() < (t == 2 ? 2 : 1); w++) begin
        @(posedge clk_in);
      end
      chk(8'(usfc_remote_inst.got.size()), t == 2 ? 8'h02 : 8'h01);
      chk(usfc_remote_inst.got[0], t == 1 ? ch[1] : ch[2]);
      if (t == 2) chk(usfc_remote_inst.got[1], ch[3]);
      rd(4'he, t == 1 ? 8'h04 : 8'h08);
    end
    slow <= 1'b0;
    modem <= ~modem;
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rd(4'h0, 8'h00);
    rd(4'h5, {modem, 4'h0});
    repeat (3) begin
      @(posedge clk_in);
      tpush <= 1'b1;
      @(posedge clk_in);
      tpush <= 1'b0;
    end
    tpop <= 1'b1;
    @(posedge clk_in);
    tpop <= 1'b0;
    rd(4'h6, 8'h02);
    wr(4'h7, 8'h03);
    pulse_cnt();
    chk({7'h0, txi}, 8'h01);
    wr(4'h7, 8'h02);
    pulse_cnt();
    chk({7'h0, txi}, 8'h00);
    @(posedge clk_in);
    tpop <= 1'b1;
    @(posedge clk_in);
    tpop <= 1'b0;
    pulse_cnt();
    chk({7'h0, txi}, 8'h01);
    wr(4'h9, 8'h02);
    rxg(plain, 8'h04, 8'h04);
    pulse_cnt();
    chk({7'h0, rxi}, 8'h00);
    rxg(plain, 8'h04, 8'h04);
    pulse_cnt();
    chk({7'h0, rxi}, 8'h01);
    rd(4'h8, 8'h02);
    rpop <= 1'b1;
    @(posedge clk_in);
    rpop <= 1'b0;
    pulse_cnt();
    chk({7'h0, rxi}, 8'h00);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
